// [hw/rsa_pkg.sv]
// constants, types and command decoding shared by the spi slave access block
package rsa_pkg;

  localparam int REG_AW = 6;
  localparam int FB_AW = 7;
  localparam int REG_DEPTH = 64;
  localparam int FB_DEPTH = 128;

  localparam logic [5:0] CTRL_ONE_ADDR = 6'h04;
  localparam int ECHO_MODE_LSB = 2;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] ECHO_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] IDX_CMD = 8'h00;
  localparam logic [7:0] IDX_SECOND = 8'h01;
  localparam logic [7:0] IDX_MAX = 8'hff;
  localparam logic [7:0] FB_WR_LAST_IDX = 8'h80;
  localparam logic [7:0] FB_RD_TAIL = 8'h04;
  localparam logic [7:0] SRAM_FB_LIMIT = 8'h80;
  localparam logic [1:0] SYNC_INIT = 2'b11;

  // master side limit on sclk when not derived from the device clock output
  localparam real SCLK_ASYNC_MAX_MHZ = 7.5;

  typedef enum logic [2:0] {
    SRC_ZERO,
    SRC_REG,
    SRC_FB,
    SRC_LQI,
    SRC_ED,
    SRC_RXS
  } rsa_src_type;

  typedef enum logic [2:0] {
    ACC_REG_RD,
    ACC_REG_WR,
    ACC_FB_RD,
    ACC_FB_WR,
    ACC_SRAM_RD,
    ACC_SRAM_WR
  } rsa_acc_type;

  function automatic rsa_acc_type rsa_decode(input logic [7:0] cmd);
    rsa_acc_type a;
    if (cmd[7]) begin
      a = cmd[6] ? ACC_REG_WR : ACC_REG_RD;
    end else if (cmd[5]) begin
      a = cmd[6] ? ACC_FB_WR : ACC_FB_RD;
    end else begin
      a = cmd[6] ? ACC_SRAM_WR : ACC_SRAM_RD;
    end
    return a;
  endfunction

endpackage

// [hw/rsa_mem_if.sv]
// carrier between the access logic and a byte memory
`timescale 1ns/1ps
interface rsa_mem_if #(parameter int AW = 6) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport user (output wr_en, output wr_addr, output wr_data, output rd_en,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en,
    input rd_addr, output rd_data);
endinterface

// [hw/rsa_mem.sv]
// byte memory written on the core clock and read on the link clock
`timescale 1ns/1ps
module rsa_mem #(
  parameter int AW = 6,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_clk,
  rsa_mem_if.mem mif
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] data;
  } rsa_mem_state_type;

  rsa_mem_state_type m_r;
  rsa_mem_state_type m_nxt;
  logic [7:0] rd_r;

  // cleared on reset so register reads start at zero; the echo field is reset separately in the core
  always_comb begin
    m_nxt = m_r;
    if (rst) begin
      m_nxt = '0;
    end else if (mif.wr_en) begin
      m_nxt.data[mif.wr_addr] = mif.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    m_r <= m_nxt;
  end

  // read side: entries are only written between bytes, so they are stable here
  always_ff @(posedge rd_clk or posedge rst) begin
    if (rst) begin
      rd_r <= 8'h00;
    end else if (mif.rd_en) begin
      rd_r <= m_r.data[mif.rd_addr];
    end
  end

  assign mif.rd_data = rd_r;
endmodule

// [hw/rsa_spi_slave.sv]
// spi slave access front end: command decode, register and frame buffer access
//
// Behaviour
// [RULE_01] master frames each transaction with select low
// [RULE_02] eight sclk cycles per byte, msb first
// [RULE_03] async sclk at most 7.5 mhz
// [RULE_04] miso driver enabled while select low
// [RULE_05] master or pull-up holds idle miso
// [RULE_06] sample mosi on rise, update miso on fall
// [RULE_07] master sends a byte to receive one
// [RULE_08] bit7 register access, bit6 write, address 5:0
// [RULE_09] bit5 frame buffer else sram, bit6 write
// [RULE_10] first miso byte is the status echo
// [RULE_11] register addresses 0x00 to 0x3f
// [RULE_12] register read returns data in second byte
// [RULE_13] register write stores the second mosi byte
// [RULE_14] register access is two bytes, then deselect
// [RULE_15] frame buffer address restarts at zero, increments
// [RULE_16] frame buffer holds up to 128 bytes
// [RULE_17] frame access: command, length byte, payload
// [RULE_18] frame read ends with lqi, ed, rx status
// [RULE_19] deselect ends a frame read cleanly
// [RULE_20] master ignores don't-care miso bytes
// [RULE_21] next frame read restarts at length byte
// [RULE_22] frame buffer violations raise the violation interrupt
// [RULE_23] sram: address byte, then data from third byte
// [RULE_24] sclk bytes cross safely into the core clock
// [RULE_25] deselect mid-byte drops the partial byte
`timescale 1ns/1ps
module rsa_spi_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_sel_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic radio_wr_en,
  input wire logic [rsa_pkg::FB_AW-1:0] radio_wr_addr,
  input wire logic [7:0] radio_wr_data,
  input wire logic [7:0] lqi_val,
  input wire logic [7:0] ed_val,
  input wire logic [7:0] rx_status_val,
  input wire logic [7:0] status_a,
  input wire logic [7:0] status_b,
  input wire logic [7:0] status_c,
  output logic [7:0] transceiver_control_one,
  output logic buffer_access_violation_irq
);
  import rsa_pkg::*;

  // link side, cleared by select high so a partial byte never survives
  typedef struct packed {
    logic [2:0] bits;
    logic [6:0] sh;
    logic [7:0] idx;
    rsa_acc_type acc;
    rsa_src_type src;
    logic [7:0] rd_addr;
    logic [6:0] phr;
  } rsa_frame_type;

  // hand-over of completed bytes, kept across frames
  typedef struct packed {
    logic tgl;
    logic [7:0] data;
    logic [7:0] idx;
  } rsa_link_type;

  typedef struct packed {
    logic started;
    logic [7:0] tx;
  } rsa_tx_type;

  typedef struct packed {
    logic [2:0] tg;
    logic [1:0] sel;
    rsa_acc_type acc;
    logic [5:0] reg_addr;
    logic [7:0] sram_addr;
    logic [6:0] phr;
    logic fb_act;
    logic [7:0] ctrl;
    logic [7:0] echo;
    logic [7:0] lqi;
    logic [7:0] ed;
    logic [7:0] rxs;
    logic irq;
  } rsa_core_type;

  rsa_frame_type f_r;
  rsa_frame_type f_nxt;
  rsa_link_type l_r;
  rsa_link_type l_nxt;
  rsa_tx_type t_r;
  rsa_tx_type t_nxt;
  rsa_core_type c_r;
  rsa_core_type c_nxt;

  rsa_mem_if #(.AW(REG_AW)) reg_if ();
  rsa_mem_if #(.AW(FB_AW)) fb_if ();

  rsa_mem #(.AW(REG_AW), .DEPTH(REG_DEPTH)) u_regs (
    .clk(clk),
    .rst(rst),
    .rd_clk(spi_sclk),
    .mif(reg_if)
  );

  rsa_mem #(.AW(FB_AW), .DEPTH(FB_DEPTH)) u_fb (
    .clk(clk),
    .rst(rst),
    .rd_clk(spi_sclk),
    .mif(fb_if)
  );

  // link clock, rising edge: shift in mosi and plan the next miso byte
  always_comb begin
    logic [7:0] byte_in;
    logic [6:0] eff_phr;
    logic [7:0] a;
    byte_in = {f_r.sh, spi_mosi}; // RULE_02 RULE_06
    eff_phr = f_r.phr;
    a = f_r.rd_addr;
    f_nxt = f_r;
    l_nxt = l_r;
    reg_if.rd_en = 1'b0;
    reg_if.rd_addr = byte_in[REG_AW-1:0];
    fb_if.rd_en = 1'b0;
    fb_if.rd_addr = f_r.idx[FB_AW-1:0];
    f_nxt.bits = f_r.bits + 3'h1;
    f_nxt.sh = byte_in[6:0];
    if (f_r.bits == BIT_LAST) begin
      l_nxt.tgl = ~l_r.tgl; // RULE_24
      l_nxt.data = byte_in;
      l_nxt.idx = f_r.idx;
      f_nxt.src = SRC_ZERO; // RULE_20
      if (f_r.idx != IDX_MAX) begin
        f_nxt.idx = f_r.idx + 8'h01;
      end
      if (f_r.idx == IDX_CMD) begin
        f_nxt.acc = rsa_decode(byte_in); // RULE_08 RULE_09
        if (rsa_decode(byte_in) == ACC_REG_RD) begin
          reg_if.rd_en = 1'b1; // RULE_11 RULE_12
          f_nxt.src = SRC_REG;
        end else if (rsa_decode(byte_in) == ACC_FB_RD) begin
          fb_if.rd_en = 1'b1; // RULE_15 RULE_21
          fb_if.rd_addr = '0;
          f_nxt.src = SRC_FB;
        end
      end else begin
        unique case (f_r.acc)
          ACC_FB_RD: begin
            // length byte arrives in read data as the second byte starts and is still there when it ends
            if (f_r.idx == IDX_SECOND) begin
              eff_phr = fb_if.rd_data[6:0];
              f_nxt.phr = fb_if.rd_data[6:0];
            end
            if (f_r.idx <= {1'b0, eff_phr}) begin
              fb_if.rd_en = 1'b1; // RULE_15 RULE_17
              f_nxt.src = SRC_FB;
            end else if (f_r.idx == {1'b0, eff_phr} + 8'h01) begin
              f_nxt.src = SRC_LQI; // RULE_18
            end else if (f_r.idx == {1'b0, eff_phr} + 8'h02) begin
              f_nxt.src = SRC_ED;
            end else if (f_r.idx == {1'b0, eff_phr} + 8'h03) begin
              f_nxt.src = SRC_RXS;
            end
          end
          ACC_SRAM_RD: begin
            if (f_r.idx == IDX_SECOND) begin
              a = byte_in; // RULE_23
            end
            // only the frame buffer part of the sram space is served here
            if (a < SRAM_FB_LIMIT) begin
              fb_if.rd_en = 1'b1;
              fb_if.rd_addr = a[FB_AW-1:0];
              f_nxt.src = SRC_FB;
            end
            f_nxt.rd_addr = a + 8'h01;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // select high clears the frame state asynchronously, dropping any partial byte
  always_ff @(posedge spi_sclk or posedge spi_sel_n) begin
    if (spi_sel_n) begin
      f_r <= '{bits: BIT_FIRST, sh: '0, idx: IDX_CMD, acc: ACC_REG_RD, src: SRC_ZERO,
        rd_addr: '0, phr: '0}; // RULE_25 RULE_19
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // link clock, falling edge: load a fresh byte at each boundary, else shift
  always_comb begin
    logic [7:0] next_byte;
    next_byte = ZERO_BYTE;
    unique case (f_r.src)
      SRC_REG: next_byte = reg_if.rd_data;
      SRC_FB: next_byte = fb_if.rd_data;
      SRC_LQI: next_byte = c_r.lqi;
      SRC_ED: next_byte = c_r.ed;
      SRC_RXS: next_byte = c_r.rxs;
      default: next_byte = ZERO_BYTE;
    endcase
    t_nxt.started = 1'b1;
    if (!t_r.started) begin
      t_nxt.tx = {c_r.echo[6:0], 1'b0}; // RULE_10
    end else if (f_r.bits == BIT_FIRST) begin
      t_nxt.tx = next_byte;
    end else begin
      t_nxt.tx = {t_r.tx[6:0], 1'b0}; // RULE_06
    end
  end

  always_ff @(negedge spi_sclk or posedge spi_sel_n) begin
    if (spi_sel_n) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  // echo msb must stand before the first sclk edge, so it comes straight from core
  assign spi_miso_o = t_r.started ? t_r.tx[7] : c_r.echo[7]; // RULE_10
  assign spi_miso_oe = ~spi_sel_n; // RULE_04

  // core clock: take completed bytes and act on writes
  always_comb begin
    logic evt;
    logic spi_fb_wr;
    logic [7:0] k;
    evt = c_r.tg[2] ^ c_r.tg[1]; // RULE_24
    k = l_r.idx;
    spi_fb_wr = 1'b0;
    c_nxt = c_r;
    c_nxt.tg = {c_r.tg[1:0], l_r.tgl};
    c_nxt.sel = {c_r.sel[0], spi_sel_n};
    c_nxt.irq = 1'b0;
    reg_if.wr_en = 1'b0;
    reg_if.wr_addr = c_r.reg_addr;
    reg_if.wr_data = l_r.data;
    fb_if.wr_en = 1'b0;
    fb_if.wr_addr = radio_wr_addr;
    fb_if.wr_data = radio_wr_data;
    // values shown on miso are frozen while a frame is in progress
    if (c_r.sel[1]) begin
      c_nxt.fb_act = 1'b0;
      c_nxt.lqi = lqi_val;
      c_nxt.ed = ed_val;
      c_nxt.rxs = rx_status_val;
      unique case (c_r.ctrl[ECHO_MODE_LSB +: 2])
        2'h0: c_nxt.echo = ZERO_BYTE;
        2'h1: c_nxt.echo = status_a;
        2'h2: c_nxt.echo = status_b;
        2'h3: c_nxt.echo = status_c;
      endcase
    end
    if (evt) begin
      if (k == IDX_CMD) begin
        c_nxt.acc = rsa_decode(l_r.data); // RULE_08 RULE_09
        c_nxt.reg_addr = l_r.data[5:0];
        c_nxt.fb_act = ~l_r.data[7];
      end else begin
        unique case (c_r.acc)
          ACC_REG_WR: begin
            if (k == IDX_SECOND) begin
              reg_if.wr_en = 1'b1; // RULE_13 RULE_14
              if (c_r.reg_addr == CTRL_ONE_ADDR) begin
                c_nxt.ctrl = l_r.data; // RULE_10
              end
            end
          end
          ACC_FB_WR: begin
            if (k <= FB_WR_LAST_IDX) begin
              spi_fb_wr = 1'b1; // RULE_15 RULE_16 RULE_17
              fb_if.wr_addr = 7'(k - 8'h01);
              if (k == IDX_SECOND) begin
                c_nxt.phr = l_r.data[6:0];
              end
            end else begin
              c_nxt.irq = 1'b1; // RULE_22
            end
          end
          ACC_SRAM_WR: begin
            if (k == IDX_SECOND) begin
              c_nxt.sram_addr = l_r.data; // RULE_23
            end else begin
              if (c_r.sram_addr < SRAM_FB_LIMIT) begin
                spi_fb_wr = 1'b1;
                fb_if.wr_addr = c_r.sram_addr[FB_AW-1:0];
                if (c_r.sram_addr == ZERO_BYTE) begin
                  c_nxt.phr = l_r.data[6:0];
                end
              end
              c_nxt.sram_addr = c_r.sram_addr + 8'h01;
            end
          end
          ACC_FB_RD: begin
            if (k > {1'b0, c_r.phr} + FB_RD_TAIL) begin
              c_nxt.irq = 1'b1; // RULE_22
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (spi_fb_wr) begin
      fb_if.wr_en = 1'b1;
      fb_if.wr_data = l_r.data;
    end
    // radio writes lose against an spi buffer access and flag the clash
    if (radio_wr_en) begin
      if (spi_fb_wr || c_r.fb_act) begin
        c_nxt.irq = 1'b1; // RULE_22
      end else begin
        fb_if.wr_en = 1'b1;
        if (radio_wr_addr == 7'h00) begin
          c_nxt.phr = radio_wr_data[6:0];
        end
      end
    end
    if (rst) begin
      c_nxt = '{tg: '0, sel: SYNC_INIT, acc: ACC_REG_RD, reg_addr: '0, sram_addr: '0,
        phr: '0, fb_act: 1'b0, ctrl: CTRL_ONE_RESET, echo: ECHO_RESET, lqi: '0, ed: '0,
        rxs: '0, irq: 1'b0};
      reg_if.wr_en = 1'b0;
      fb_if.wr_en = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    c_r <= c_nxt;
  end

  assign transceiver_control_one = c_r.ctrl;
  assign buffer_access_violation_irq = c_r.irq;
endmodule

// [verif/rsa_spi_host.sv]
// spi master model on the far side of the link
`timescale 1ns/1ps
module rsa_spi_host (
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    // nba so the asynchronous frame clears in the slave see this edge
    sel_n <= 1'b1;
    mosi = 1'b0;
  end
  task automatic open_frame();
    #7;
    sel_n = 1'b0;
    #50;
  endtask
  // mosi moves while sclk is low, miso is taken at the rise
  // 32 ns period models an sclk taken from the device clock output; an async
  // master would have to slow down to the package limit
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      mosi = tx[i];
      #16;
      sclk = 1'b1;
      rx[i] = miso;
      #16;
      sclk = 1'b0;
    end
  endtask
  // sclk stands still low between frames
  task automatic close_frame();
    #16;
    sel_n = 1'b1;
    mosi = ~mosi;
    #700;
  endtask
endmodule

// [verif/rsa_chk_chk.sv]
// port assertions for the spi slave access block
`timescale 1ns/1ps
module rsa_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_sel_n,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  input wire logic radio_wr_en,
  input wire logic [7:0] status_a,
  input wire logic [7:0] status_b,
  input wire logic [7:0] status_c,
  input wire logic [7:0] transceiver_control_one,
  input wire logic buffer_access_violation_irq
);
  logic [3:0] hi_cnt_r;
  logic rise_r;
  logic [7:0] echo;
  // saturating count of core cycles with select high
  always_ff @(posedge clk) begin
    if (rst || !spi_sel_n) begin
      hi_cnt_r <= 4'h0;
    end else if (hi_cnt_r != 4'hf) begin
      hi_cnt_r <= hi_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge spi_sclk) begin
    rise_r <= spi_miso_o;
  end
  always_comb begin
    case (transceiver_control_one[3:2])
      2'h1: echo = status_a;
      2'h2: echo = status_b;
      2'h3: echo = status_c;
      default: echo = 8'h00;
    endcase
  end
  a_oe_core: assert property (@(posedge clk) disable iff (rst)
    spi_miso_oe == !spi_sel_n) else $error("miso enable off select");
  a_oe_link: assert property (@(posedge spi_sclk) disable iff (rst)
    spi_miso_oe) else $error("miso enable low while clocking");
  a_miso_rise: assert property (@(negedge spi_sclk) disable iff (rst || spi_sel_n)
    spi_miso_o == rise_r) else $error("miso moved on rising sclk");
  a_echo_msb: assert property (@(posedge clk) disable iff (rst)
    $fell(spi_sel_n) && hi_cnt_r == 4'hf |-> spi_miso_o == echo[7])
    else $error("echo msb wrong");
  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    $changed(transceiver_control_one) |-> hi_cnt_r <= 4'h8) else $error("stray control change");
  a_reset_vals: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> transceiver_control_one == 8'h00 && !buffer_access_violation_irq)
    else $error("reset values wrong");
  a_irq_pulse: assert property (@(posedge clk) disable iff (rst)
    buffer_access_violation_irq |=> !buffer_access_violation_irq) else $error("irq too long");
  a_irq_cause: assert property (@(posedge clk) disable iff (rst)
    buffer_access_violation_irq |-> hi_cnt_r <= 4'h8 || $past(radio_wr_en)
    || $past(radio_wr_en, 2)) else $error("irq without access");
endmodule

// [verif/testbench.sv]
// self-checking bench for the spi slave access block
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire miso;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ctrl;
  logic irq;
  logic irq_seen;
  logic [7:0] sv [0:6];
  logic [7:0] txb [0:9];
  logic [7:0] rxb [0:9];
  int bad_count;
  int cmp_count;
  // no pull-up inside the device, the board supplies it
  assign miso = miso_oe ? miso_o : 1'b1;
  rsa_spi_slave i_rsa_spi_slave (
    .clk(clk),
    .rst(rst),
    .spi_sclk(sclk),
    .spi_sel_n(sel_n),
    .spi_mosi(mosi),
    .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe),
    .radio_wr_en(wr_en),
    .radio_wr_addr(wr_addr),
    .radio_wr_data(wr_data),
    .lqi_val(sv[4]),
    .ed_val(sv[5]),
    .rx_status_val(sv[6]),
    .status_a(sv[1]),
    .status_b(sv[2]),
    .status_c(sv[3]),
    .transceiver_control_one(ctrl),
    .buffer_access_violation_irq(irq)
  );
  rsa_spi_host i_rsa_spi_host (
    .sclk(sclk),
    .sel_n(sel_n),
    .mosi(mosi),
    .miso(miso)
  );
  initial begin
    clk = 1'b0;
    forever begin
      #20 clk = ~clk;
    end
  end
  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_seen <= 1'b1;
    end
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input int n);
    i_rsa_spi_host.open_frame();
    for (int i = 0; i < n; i++) begin
      i_rsa_spi_host.xbits(txb[i], 8, rxb[i]);
    end
    i_rsa_spi_host.close_frame();
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    txb[0] = {2'b11, a};
    txb[1] = d;
    // the echo byte and the don't-care byte answering a write both stay unchecked
    run(2);
  endtask
  task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
    txb[0] = {2'b10, a};
    run(2);
    chk(rxb[1], exp, "reg read");
  endtask
  task automatic wait_ctrl(input logic [7:0] exp);
    for (int n = 0; n < 20 && ctrl !== exp; n++) begin
      @(posedge clk);
    end
    chk(ctrl, exp, "control copy");
    if (ctrl !== exp) begin
      wrap_up();
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic radio_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic t_reset();
    chk(ctrl, 8'h00, "control at reset");
    reg_rd(6'h04, 8'h00);
    chk(rxb[0], 8'h00, "echo at reset");
    $display("reset test done");
  endtask
  task automatic t_regs();
    for (int k = 0; k < 4; k++) begin
      reg_wr(6'h3f - 6'(k) * 6'h15, 8'ha5 ^ (8'h3f - 8'(k) * 8'h15));
    end
    for (int k = 0; k < 4; k++) begin
      reg_rd(6'h3f - 6'(k) * 6'h15, 8'ha5 ^ (8'h3f - 8'(k) * 8'h15));
    end
    $display("register test done");
  endtask
  task automatic t_echo();
    for (int m = 0; m < 4; m++) begin
      reg_wr(6'h04, {4'h0, 2'(m), 2'b00});
      wait_ctrl({4'h0, 2'(m), 2'b00});
      txb[0] = 8'h80;
      run(2);
      chk(rxb[0], sv[m], "echo byte");
    end
    reg_wr(6'h04, 8'h00);
    wait_ctrl(8'h00);
    $display("echo test done");
  endtask
  task automatic t_fb_read();
    radio_wr(7'h00, 8'h03);
    for (int i = 1; i < 4; i++) begin
      radio_wr(7'(i), 8'he0 | 8'(i));
    end
    repeat (4) @(posedge clk);
    irq_seen = 1'b0;
    // reserved low bits set on purpose
    txb[0] = 8'h3f;
    run(9);
    chk(rxb[1], 8'h03, "length");
    for (int i = 1; i < 7; i++) begin
      chk(rxb[i + 1], i < 4 ? 8'he0 | 8'(i) : sv[i], "frame byte");
    end
    chk({7'h0, irq_seen}, 8'h01, "overrun irq");
    irq_seen = 1'b0;
    run(2);
    chk(rxb[1], 8'h03, "length on abort");
    run(5);
    chk(rxb[4], 8'he3, "restart");
    chk({7'h0, irq_seen}, 8'h00, "quiet abort");
    $display("frame read test done");
  endtask
  task automatic t_fb_write();
    txb = '{8'h7f, 8'h02, 8'hc1, 8'hc2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    run(4);
    txb[0] = 8'h20;
    run(5);
    chk(rxb[1], 8'h02, "written length");
    chk(rxb[3], 8'hc2, "written payload");
    chk(rxb[4], sv[4], "tail after write");
    txb[0] = 8'h5f;
    txb[1] = 8'h05;
    txb[2] = 8'hd5;
    run(3);
    txb[0] = 8'h1f;
    txb[1] = 8'h01;
    run(4);
    chk(rxb[2], 8'hc1, "sram read");
    txb[1] = 8'h05;
    run(3);
    chk(rxb[2], 8'hd5, "sram write");
    $display("frame write test done");
  endtask
  task automatic t_abort();
    i_rsa_spi_host.open_frame();
    i_rsa_spi_host.xbits(8'hd5, 8, rxb[0]);
    i_rsa_spi_host.xbits(8'h3c, 4, rxb[1]);
    i_rsa_spi_host.close_frame();
    reg_rd(6'h15, 8'hb0);
    $display("abort test done");
  endtask
  initial begin
    rst <= 1'b1;
    wr_en = 1'b0;
    wr_addr = 7'h00;
    wr_data = 8'h00;
    irq_seen = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    sv = '{8'h00, 8'h3c, 8'hc3, 8'h96, 8'h71, 8'h72, 8'h73};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_echo();
    t_fb_read();
    t_fb_write();
    t_abort();
    wrap_up();
  end
endmodule
bind rsa_spi_slave rsa_chk i_rsa_chk (
  .clk(clk),
  .rst(rst),
  .spi_sclk(spi_sclk),
  .spi_sel_n(spi_sel_n),
  .spi_miso_o(spi_miso_o),
  .spi_miso_oe(spi_miso_oe),
  .radio_wr_en(radio_wr_en),
  .status_a(status_a),
  .status_b(status_b),
  .status_c(status_c),
  .transceiver_control_one(transceiver_control_one),
  .buffer_access_violation_irq(buffer_access_violation_irq)
);
